// ===== src/adc_flag_pkg.sv
package adc_flag_pkg;
  localparam int NUM_CHANNELS  = 8;
  localparam int RESULT_WIDTH  = 10;
  localparam int ADDR_WIDTH    = 8;
  localparam int DATA_WIDTH    = 32;

  // Register offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_MODE      = 8'h04;
  localparam logic [7:0] OFS_CH_ENABLE = 8'h10;
  localparam logic [7:0] OFS_CH_DISABLE = 8'h14;
  localparam logic [7:0] OFS_CH_STATUS = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1C;
  localparam logic [7:0] OFS_LAST      = 8'h20;
  localparam logic [7:0] OFS_INT_MASK  = 8'h2C;
  localparam logic [7:0] OFS_INT_STAT  = 8'h30;
  localparam logic [7:0] OFS_CH_BASE   = 8'h40;

  // Field positions
  localparam int CTRL_START_BIT  = 1;
  localparam int MODE_SLEEP_BIT  = 5;
  localparam int ST_OVR_LSB      = 8;
  localparam int ST_READY_BIT    = 16;
  localparam int ST_GOVR_BIT     = 17;
  localparam int LAST_CH_LSB     = 12;

  // Interrupt status bits
  localparam int IRQ_READY = 0;
  localparam int IRQ_GOVR  = 1;
  localparam int IRQ_OVR   = 2;
  localparam int IRQ_WIDTH = 3;

  // Reset values
  localparam logic [31:0] MODE_RESET = 32'h0000_0000;
  localparam logic [7:0]  EN_RESET   = 8'h00;

  typedef enum logic [1:0] {
    PWR_IDLE  = 2'b00,
    PWR_CONV  = 2'b01,
    PWR_SLEEP = 2'b10
  } power_state_type;
endpackage : adc_flag_pkg

// ===== src/conv_event_if.sv
`timescale 1ns/1ps
interface conv_event_if
  import adc_flag_pkg::*;
();
  logic                      eoc_pulse;
  logic [2:0]                eoc_channel;
  logic [RESULT_WIDTH-1:0]   eoc_data;

  modport src (output eoc_pulse, output eoc_channel, output eoc_data);
  modport dst (input eoc_pulse, input eoc_channel, input eoc_data);
endinterface : conv_event_if

// ===== src/adc_power_ctrl.sv
`timescale 1ns/1ps
module adc_power_ctrl
  import adc_flag_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic sleep_sel,
  input  wire logic start_req,
  input  wire logic conv_done,
  output logic      core_powered,
  output logic      conv_start,
  output logic      asleep
);
  power_state_type state_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= PWR_IDLE;
    end else begin
      unique case (state_r)
        PWR_IDLE: begin
          if (start_req)
            state_r <= PWR_CONV;
          else if (sleep_sel)
            state_r <= PWR_SLEEP;
        end
        PWR_CONV: begin
          if (conv_done)
            state_r <= sleep_sel ? PWR_SLEEP : PWR_IDLE;
        end
        PWR_SLEEP: begin
          if (start_req)
            state_r <= PWR_CONV;
          else if (!sleep_sel)
            state_r <= PWR_IDLE;
        end
        default: state_r <= PWR_IDLE;
      endcase
    end
  end

  assign core_powered = (state_r != PWR_SLEEP);
  assign asleep       = (state_r == PWR_SLEEP);
  assign conv_start   = start_req && (state_r != PWR_CONV);
endmodule : adc_power_ctrl

// ===== src/adc_result_store.sv
`timescale 1ns/1ps
module adc_result_store
  import adc_flag_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  conv_event_if.dst                    evt,
  input  wire logic                    store_en,
  input  wire logic [2:0]              rd_channel,
  output logic [RESULT_WIDTH-1:0]      ch_value,
  output logic [RESULT_WIDTH-1:0]      last_value,
  output logic [2:0]                   last_channel
);
  logic [RESULT_WIDTH-1:0] channel_result_register [NUM_CHANNELS];
  logic [RESULT_WIDTH-1:0] latest_result_reg;
  logic [2:0]              last_ch_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CHANNELS; i++)
        channel_result_register[i] <= '0;
      latest_result_reg <= '0;
      last_ch_r         <= '0;
    end else if (evt.eoc_pulse && store_en) begin
      channel_result_register[evt.eoc_channel] <= evt.eoc_data;
      latest_result_reg                        <= evt.eoc_data;
      last_ch_r                                <= evt.eoc_channel;
    end
  end

  assign ch_value     = channel_result_register[rd_channel];
  assign last_value   = latest_result_reg;
  assign last_channel = last_ch_r;
endmodule : adc_result_store

// ===== src/adc_result_flag_logic.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
module adc_result_flag_logic
  import adc_flag_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic [ADDR_WIDTH-1:0]  addr,
  input  wire logic [DATA_WIDTH-1:0]  wdata,
  input  wire logic                   wr_stb,
  input  wire logic                   rd_stb,
  output logic      [DATA_WIDTH-1:0]  rdata,
  input  wire logic                   eoc_pulse,
  input  wire logic [2:0]             eoc_channel,
  input  wire logic [RESULT_WIDTH-1:0] eoc_data,
  output logic                        conv_start,
  output logic                        core_powered,
  output logic                        irq
);
  conv_event_if evt ();

  logic [NUM_CHANNELS-1:0] ch_en_r;
  logic [NUM_CHANNELS-1:0] eoc_flag_r;
  logic [NUM_CHANNELS-1:0] channel_overrun_flag;
  logic                    result_ready_flag;
  logic                    general_overrun_flag;
  logic                    sleep_r;
  logic [IRQ_WIDTH-1:0]    irq_stat_r;
  logic [IRQ_WIDTH-1:0]    irq_mask_r;
  logic [DATA_WIDTH-1:0]   rdata_r;
  logic [DATA_WIDTH-1:0]   rdata_nxt;
  logic [RESULT_WIDTH-1:0] ch_value;
  logic [RESULT_WIDTH-1:0] last_value;
  logic [2:0]              last_channel;
  logic                    asleep;

  function automatic logic is_channel_addr(input logic [ADDR_WIDTH-1:0] a);
    return (a >= OFS_CH_BASE) && (a < OFS_CH_BASE + 8'(4 * NUM_CHANNELS)) && (a[1:0] == 2'b00);
  endfunction : is_channel_addr

  function automatic logic [2:0] channel_of(input logic [ADDR_WIDTH-1:0] a);
    logic [ADDR_WIDTH-1:0] d;
    d = a - OFS_CH_BASE;
    return d[4:2];
  endfunction : channel_of

  assign evt.eoc_pulse   = eoc_pulse;
  assign evt.eoc_channel = eoc_channel;
  assign evt.eoc_data    = eoc_data;

  // Access decode
  logic                    rd_last;
  logic                    rd_status;
  logic                    rd_chan;
  logic [2:0]              rd_ch_idx;
  logic                    wr_disable;
  logic                    wr_enable;
  logic [NUM_CHANNELS-1:0] dis_mask;
  logic [NUM_CHANNELS-1:0] en_mask;
  logic                    eoc_valid;
  logic [NUM_CHANNELS-1:0] eoc_onehot;
  logic [NUM_CHANNELS-1:0] clr_eoc;
  logic                    new_govr;
  logic [NUM_CHANNELS-1:0] new_ovr;

  assign rd_last    = rd_stb && (addr == OFS_LAST);
  assign rd_status  = rd_stb && (addr == OFS_STATUS);
  assign rd_chan    = rd_stb && is_channel_addr(addr);
  assign rd_ch_idx  = channel_of(addr);
  assign wr_disable = wr_stb && (addr == OFS_CH_DISABLE);
  assign wr_enable  = wr_stb && (addr == OFS_CH_ENABLE);
  assign dis_mask   = wr_disable ? wdata[NUM_CHANNELS-1:0] : '0;
  assign en_mask    = wr_enable ? wdata[NUM_CHANNELS-1:0] : '0;

  // Result stored only for a channel enabled when its conversion ends
  assign eoc_valid  = eoc_pulse && ch_en_r[eoc_channel] && !dis_mask[eoc_channel];
  assign eoc_onehot = eoc_valid ? (NUM_CHANNELS'(1) << eoc_channel) : '0;

  // Clear only the channel actually addressed, or all on last-result read
  always_comb begin
    clr_eoc = '0;
    if (rd_last)
      clr_eoc = '1;
    else if (rd_chan)
      clr_eoc[rd_ch_idx] = 1'b1;
  end

  assign new_govr = eoc_valid && result_ready_flag;
  assign new_ovr  = eoc_onehot & eoc_flag_r;

  adc_result_store u_store (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .evt          (evt.dst),
    .store_en     (eoc_valid),
    .rd_channel   (rd_ch_idx),
    .ch_value     (ch_value),
    .last_value   (last_value),
    .last_channel (last_channel)
  );

  adc_power_ctrl u_power (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .sleep_sel    (sleep_r),
    .start_req    (wr_stb && (addr == OFS_CONTROL) && wdata[CTRL_START_BIT]),
    .conv_done    (eoc_pulse),
    .core_powered (core_powered),
    .conv_start   (conv_start),
    .asleep       (asleep)
  );

  // Channel enables
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      ch_en_r <= EN_RESET;
    else
      ch_en_r <= (ch_en_r | en_mask) & ~dis_mask;
  end

  // Mode register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      sleep_r <= MODE_RESET[MODE_SLEEP_BIT];
    else if (wr_stb && (addr == OFS_MODE))
      sleep_r <= wdata[MODE_SLEEP_BIT];
  end

  // End-of-conversion flags: set wins over clear, disable drops the flag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      eoc_flag_r <= '0;
    else
      eoc_flag_r <= ((eoc_flag_r & ~clr_eoc) | eoc_onehot) & ~dis_mask;
  end

  // Result-ready: set on stored end, cleared only by last-result read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      result_ready_flag <= 1'b0;
    else if (eoc_valid)
      result_ready_flag <= 1'b1;
    else if (rd_last)
      result_ready_flag <= 1'b0;
  end

  // Channel overrun: status read clears, new overrun sets
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      channel_overrun_flag <= '0;
    else if (rd_status)
      channel_overrun_flag <= new_ovr;
    else
      channel_overrun_flag <= channel_overrun_flag | new_ovr;
  end

  // General overrun: new overrun wins over status-read clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      general_overrun_flag <= 1'b0;
    else if (new_govr)
      general_overrun_flag <= 1'b1;
    else if (rd_status)
      general_overrun_flag <= 1'b0;
  end

  // Interrupt status, write one to clear, set wins
  logic [IRQ_WIDTH-1:0] irq_evt;
  logic [IRQ_WIDTH-1:0] irq_clr;
  assign irq_evt = {|new_ovr, new_govr, eoc_valid};
  assign irq_clr = (wr_stb && (addr == OFS_INT_STAT)) ? wdata[IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      irq_mask_r <= '0;
    else if (wr_stb && (addr == OFS_INT_MASK))
      irq_mask_r <= wdata[IRQ_WIDTH-1:0];
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read mux
  always_comb begin
    rdata_nxt = '0;
    if (rd_chan) begin
      rdata_nxt[RESULT_WIDTH-1:0] = ch_value;
    end else begin
      unique case (addr)
        OFS_MODE:      rdata_nxt[MODE_SLEEP_BIT] = sleep_r;
        OFS_CH_STATUS: rdata_nxt[NUM_CHANNELS-1:0] = ch_en_r;
        OFS_STATUS: begin
          rdata_nxt[NUM_CHANNELS-1:0]                   = eoc_flag_r;
          rdata_nxt[ST_OVR_LSB +: NUM_CHANNELS]          = channel_overrun_flag;
          rdata_nxt[ST_READY_BIT]                        = result_ready_flag;
          rdata_nxt[ST_GOVR_BIT]                         = general_overrun_flag;
          rdata_nxt[ST_GOVR_BIT+1]                       = asleep;
        end
        OFS_LAST: begin
          rdata_nxt[RESULT_WIDTH-1:0]    = last_value;
          rdata_nxt[LAST_CH_LSB +: 3]    = last_channel;
        end
        OFS_INT_MASK:  rdata_nxt[IRQ_WIDTH-1:0] = irq_mask_r;
        OFS_INT_STAT:  rdata_nxt[IRQ_WIDTH-1:0] = irq_stat_r;
        default:       rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      rdata_r <= '0;
    else if (rd_stb)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= '0;
  end

  assign rdata = rdata_r;
endmodule : adc_result_flag_logic

// ===== tb/adc_flag_chk.sv
`timescale 1ns/1ps
module adc_flag_chk
  import adc_flag_pkg::*;
(
  input wire logic                    clk_sys,
  input wire logic                    rst_n,
  input wire logic [ADDR_WIDTH-1:0]   addr,
  input wire logic [DATA_WIDTH-1:0]   wdata,
  input wire logic                    wr_stb,
  input wire logic                    rd_stb,
  input wire logic [DATA_WIDTH-1:0]   rdata,
  input wire logic                    eoc_pulse,
  input wire logic [2:0]              eoc_channel,
  input wire logic [RESULT_WIDTH-1:0] eoc_data,
  input wire logic                    conv_start,
  input wire logic                    core_powered,
  input wire logic                    irq
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [7:0] en_r, eoc_r, ovr_r, dis, rch;
  logic       rdy_r, gov_r, busy_r, slp_r, hit, st_rd, rlst;
  assign dis   = (wr_stb && addr == OFS_CH_DISABLE) ? wdata[7:0] : 8'h00;
  assign hit   = eoc_pulse && en_r[eoc_channel] && !dis[eoc_channel];
  assign st_rd = rd_stb && addr == OFS_STATUS;
  assign rlst  = rd_stb && addr == OFS_LAST;
  assign rch   = (rd_stb && addr[7:5] == 3'h2 && addr[1:0] == 2'b00) ? 8'h01 << addr[4:2] : 8'h00;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_r   <= 8'h00;
      eoc_r  <= 8'h00;
      ovr_r  <= 8'h00;
      rdy_r  <= 1'b0;
      gov_r  <= 1'b0;
      busy_r <= 1'b0;
      slp_r  <= 1'b0;
    end else begin
      en_r   <= (en_r | ((wr_stb && addr == OFS_CH_ENABLE) ? wdata[7:0] : 8'h00)) & ~dis;
      eoc_r  <= ((rlst ? 8'h00 : eoc_r & ~rch) | (hit ? 8'h01 << eoc_channel : 8'h00)) & ~dis;
      ovr_r  <= (st_rd ? 8'h00 : ovr_r) | ((hit && eoc_r[eoc_channel]) ? 8'h01 << eoc_channel : 8'h00);
      rdy_r  <= hit || (rdy_r && !rlst);
      gov_r  <= (hit && rdy_r) || (gov_r && !st_rd);
      busy_r <= conv_start || (busy_r && !eoc_pulse);
      slp_r  <= (wr_stb && addr == OFS_MODE) ? wdata[MODE_SLEEP_BIT] : slp_r;
    end
  end
  sequence sleep_req_s;
    wr_stb && addr == OFS_MODE && wdata[MODE_SLEEP_BIT] && !busy_r;
  endsequence
  sequence no_start_s;
    !(wr_stb && addr == OFS_CONTROL && wdata[CTRL_START_BIT]);
  endsequence
  sequence conv_end_s;
    eoc_pulse && busy_r && slp_r;
  endsequence
  ready_flag_a: assert property (st_rd |=> rdata[ST_READY_BIT] == $past(rdy_r))
    else $error("ready flag wrong");
  end_flags_a: assert property (st_rd |=> rdata[7:0] == $past(eoc_r))
    else $error("end flags wrong");
  chan_overrun_a: assert property (st_rd |=> rdata[15:8] == $past(ovr_r))
    else $error("channel overrun wrong");
  gen_overrun_a: assert property (st_rd |=> rdata[ST_GOVR_BIT] == $past(gov_r))
    else $error("general overrun wrong");
  idle_sleep_a: assert property (sleep_req_s ##1 no_start_s |=> !core_powered)
    else $error("no sleep from idle");
  sleep_after_a: assert property (conv_end_s |=> !core_powered)
    else $error("no sleep after conversion");
  start_cause_a: assert property (conv_start |-> wr_stb && addr == OFS_CONTROL && wdata[CTRL_START_BIT])
    else $error("start without request");
  read_quiet_a: assert property (!rd_stb |=> rdata == '0)
    else $error("read data outside read");
endmodule : adc_flag_chk
bind adc_result_flag_logic adc_flag_chk adc_flag_chk_i (.clk_sys, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
  .eoc_pulse, .eoc_channel, .eoc_data, .conv_start, .core_powered, .irq);

// ===== tb/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model
  import adc_flag_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    conv_start,
  input  wire logic                    fire,
  input  wire logic [2:0]              fire_ch,
  input  wire logic [RESULT_WIDTH-1:0] fire_data,
  output logic                         eoc_pulse,
  output logic [2:0]                   eoc_channel,
  output logic [RESULT_WIDTH-1:0]      eoc_data
);
  logic [3:0] cnt_r;
  logic       auto;
  assign auto        = cnt_r == 4'h1;
  assign eoc_pulse   = fire || auto;
  assign eoc_channel = fire ? fire_ch : (auto ? 3'h0 : 3'h5);
  assign eoc_data    = fire ? fire_data : (auto ? 10'h2A5 : ~fire_data);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= conv_start ? 4'h6 : ((cnt_r != 4'h0) ? cnt_r - 4'h1 : 4'h0);
    end
  end
endmodule : conv_core_model

// ===== tb/test_adc_result_flag_logic.sv
`timescale 1ns/1ps
module test_adc_result_flag_logic;
  import adc_flag_pkg::*;
  logic                    clk_sys = 1'b0;
  logic                    rst_n = 1'b0;
  logic [ADDR_WIDTH-1:0]   addr = '0;
  logic [DATA_WIDTH-1:0]   wdata = '0;
  logic                    wr_stb = 1'b0;
  logic                    rd_stb = 1'b0;
  logic                    fire = 1'b0;
  logic [2:0]              fire_ch = 3'h0;
  logic [RESULT_WIDTH-1:0] fire_data = '0;
  logic [DATA_WIDTH-1:0]   rdata, rv;
  logic [2:0]              eoc_channel;
  logic [RESULT_WIDTH-1:0] eoc_data;
  logic                    eoc_pulse, conv_start, core_powered, irq, cs;
  int                      n_errors = 0;
  int                      samples_checked = 0;
  adc_result_flag_logic adc_result_flag_logic_i (.clk_sys, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .eoc_pulse, .eoc_channel, .eoc_data, .conv_start, .core_powered, .irq);
  conv_core_model conv_core_model_i (.clk_sys, .rst_n, .conv_start, .fire, .fire_ch, .fire_data,
    .eoc_pulse, .eoc_channel, .eoc_data);
  always #50 clk_sys = ~clk_sys;
  task automatic op(input logic w, r, input logic [7:0] a, input logic [31:0] d,
                    input logic f, input logic [2:0] c, input logic [9:0] v);
    @(posedge clk_sys);
    wr_stb <= w;
    rd_stb <= r;
    addr <= a;
    wdata <= d;
    fire <= f;
    fire_ch <= c;
    fire_data <= v;
    #1 cs = conv_start;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    fire <= 1'b0;
    #1 rv = rdata;
  endtask : op
  task automatic chk(input string n, input logic [31:0] e, g, m);
    samples_checked++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e & m, g & m);
    end
  endtask : chk
  task automatic rs(input logic [7:0] a, input logic [31:0] e, m, input string n);
    op(0, 1, a, 0, 0, 0, 0);
    chk(n, e, rv, m);
  endtask : rs
  task automatic lo_wait(input string n);
    for (int i = 0; i < 20 && core_powered !== 1'b0; i++) begin
      @(posedge clk_sys);
      #1;
    end
    chk(n, 32'h0, {31'h0, core_powered}, 32'h1);
  endtask : lo_wait
  task automatic t_store;
    op(1, 0, OFS_CH_ENABLE, 32'h0F, 0, 0, 0);
    op(1, 0, OFS_CH_DISABLE, 32'h08, 1, 3'h1, 10'h155);
    rs(OFS_STATUS, 32'h0001_0002, 32'h0003_FFFF, "status");
    rs(OFS_CH_BASE + 8'h04, 32'h155, 32'h3FF, "ch1");
    rs(OFS_STATUS, 32'h0001_0000, 32'h0003_FFFF, "status");
    rs(OFS_LAST, 32'h1155, 32'h73FF, "last");
    rs(OFS_STATUS, 32'h0, 32'h0003_FFFF, "status");
    $display("store test done");
  endtask : t_store
  task automatic t_disabled;
    op(0, 0, 0, 0, 1, 3'h0, 10'h0AA);
    op(0, 1, OFS_LAST, 0, 1, 3'h3, 10'h3FF);
    chk("last", 32'h00AA, rv, 32'h73FF);
    rs(OFS_STATUS, 32'h0, 32'h0003_FFFF, "status");
    rs(OFS_CH_BASE + 8'h0C, 32'h0, 32'h3FF, "ch3");
    $display("disabled test done");
  endtask : t_disabled
  task automatic t_overrun;
    op(0, 0, 0, 0, 1, 3'h2, 10'h011);
    op(0, 0, 0, 0, 1, 3'h0, 10'h022);
    rs(OFS_STATUS, 32'h0003_0005, 32'h0003_FFFF, "status");
    op(0, 1, OFS_CH_BASE + 8'h04, 0, 1, 3'h2, 10'h033);
    rs(OFS_STATUS, 32'h0003_0405, 32'h0003_FFFF, "status");
    op(0, 1, OFS_STATUS, 0, 1, 3'h1, 10'h044);
    rs(OFS_STATUS, 32'h0003_0007, 32'h0003_FFFF, "status");
    rs(OFS_STATUS, 32'h0001_0007, 32'h0003_FFFF, "status");
    $display("overrun test done");
  endtask : t_overrun
  task automatic t_disable;
    op(1, 0, OFS_CH_DISABLE, 32'h02, 1, 3'h0, 10'h055);
    rs(OFS_CH_BASE, 32'h055, 32'h3FF, "ch0");
    op(0, 1, OFS_STATUS, 0, 1, 3'h0, 10'h066);
    chk("status", 32'h0003_0100, rv, 32'h0003_FF00);
    rs(OFS_STATUS, 32'h0003_0001, 32'h0003_FF01, "status");
    rs(OFS_CH_STATUS, 32'h05, 32'hFFFF_FFFF, "enabled");
    $display("disable test done");
  endtask : t_disable
  task automatic t_irq;
    op(1, 0, OFS_INT_MASK, 32'h1, 0, 0, 0);
    chk("irq", 32'h1, {31'h0, irq}, 32'h1);
    op(1, 0, OFS_INT_STAT, 32'h7, 0, 0, 0);
    chk("irq", 32'h0, {31'h0, irq}, 32'h1);
    op(1, 0, OFS_INT_MASK, 32'h0, 0, 0, 0);
    rs(OFS_INT_MASK, 32'h0, 32'hFFFF_FFFF, "int mask");
    op(0, 0, 0, 0, 1, 3'h0, 10'h077);
    chk("irq", 32'h0, {31'h0, irq}, 32'h1);
    rs(OFS_INT_STAT, 32'h1, 32'h1, "int status");
    rs(8'h3C, 32'h0, 32'hFFFF_FFFF, "unmapped");
    op(1, 0, OFS_INT_MASK, 32'h1, 0, 0, 0);
    chk("irq", 32'h1, {31'h0, irq}, 32'h1);
    $display("irq test done");
  endtask : t_irq
  task automatic t_sleep;
    op(1, 0, OFS_MODE, 32'h20, 0, 0, 0);
    lo_wait("idle sleep");
    rs(OFS_MODE, 32'h20, 32'hFFFF_FFFF, "mode");
    rs(OFS_STATUS, 32'h0004_0000, 32'h0004_0000, "asleep");
    op(1, 0, OFS_CONTROL, 32'h02, 0, 0, 0);
    chk("start", 32'h1, {31'h0, cs}, 32'h1);
    chk("awake", 32'h1, {31'h0, core_powered}, 32'h1);
    lo_wait("sleep after");
    rs(OFS_STATUS, 32'h0004_0000, 32'h0004_0000, "asleep");
    $display("sleep test done");
  endtask : t_sleep
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  initial begin
    #200000;
    n_errors++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_store;
    t_disabled;
    t_overrun;
    t_disable;
    t_irq;
    t_sleep;
    final_report;
  end
endmodule : test_adc_result_flag_logic
